/* File: hdl/jtp_pkg.sv */
// Constants and types shared by the boundary-scan test access port
package jtp_pkg;

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR    = 4'h0,
    ST_RTI    = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'hA,
    ST_SH_IR  = 4'hB,
    ST_EX1_IR = 4'hC,
    ST_PAU_IR = 4'hD,
    ST_EX2_IR = 4'hE,
    ST_UPD_IR = 4'hF
  } jtp_state_t;

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  localparam int         IR_LEN        = 4;
  localparam logic [3:0] INS_EXTEST    = 4'h0;
  localparam logic [3:0] INS_SAMPLE    = 4'h1;
  localparam logic [3:0] INS_IDCODE    = 4'h2;
  localparam logic [3:0] INS_HIGHZ     = 4'h4;
  localparam logic [3:0] INS_BYPASS    = 4'hF;
  localparam logic [3:0] IR_CAPTURE    = 4'h1;   // Low two bits 01
  localparam logic [3:0] INS_RESET     = INS_IDCODE;

  // ---------------------------------------------------------------
  // Identification word fields (values arbitrary, not a real part)
  // ---------------------------------------------------------------
  localparam int          ID_LEN       = 32;
  localparam logic [3:0]  ID_VERSION   = 4'h1;
  localparam logic [15:0] ID_PART      = 16'h5A5A;
  localparam logic [10:0] ID_MAKER     = 11'h2AB;
  localparam logic [31:0] ID_WORD      = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // ---------------------------------------------------------------
  // Boundary chain and synchroniser
  // ---------------------------------------------------------------
  localparam int          BSR_LEN      = 8;
  localparam int          TMS_RESET_N  = 5;
  localparam int          NUM_LEVELS   = 3;
  localparam logic        BYP_CAPTURE  = 1'b0;

endpackage : jtp_pkg

/* File: hdl/jtp_tap.sv */
// Boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module jtp_tap
  import jtp_pkg::*;
(
  input  wire logic               i_ref_clk,      // System clock, 200 MHz
  input  wire logic               i_rstn,         // System reset, sync, active low
  input  wire logic               i_tck,          // Test clock
  input  wire logic               i_trst_n,       // Test reset, async, active low
  input  wire logic               i_tms,          // Test mode select
  input  wire logic               i_tdi,          // Test data in
  output logic                    o_tdo,          // Test data out
  output logic                    o_tdo_oe,       // Test data out enable
  input  wire logic [BSR_LEN-1:0] i_pin_sample,   // Pin cell values to capture
  output logic      [BSR_LEN-1:0] o_bsr_drive,    // Boundary update cells
  output logic                    o_extest_mode,  // Pins driven from boundary cells
  output logic                    o_out_hiz,      // All device outputs disabled
  output logic                    o_queue_en      // Queue logic may operate
);

  // ---------------------------------------------------------------
  // Controller state machine (test clock)
  // ---------------------------------------------------------------
  jtp_state_t st_ff;
  jtp_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_TLR:    nxt_st = i_tms ? ST_TLR    : ST_RTI;
      // No instruction defines a self test, so idle stays quiet
      ST_RTI:    nxt_st = i_tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: nxt_st = i_tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_st = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nxt_st = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_st = i_tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_st = i_tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_st = i_tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_st = i_tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: nxt_st = i_tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: nxt_st = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nxt_st = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_st = i_tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_st = i_tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_st = i_tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_st = i_tms ? ST_SEL_DR : ST_RTI;
      default:   nxt_st = ST_TLR;
    endcase
  end

  // No power-up reset exists besides TRST; TMS-high clocks recover it
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      st_ff <= ST_TLR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Decode of state and instruction
  // ---------------------------------------------------------------
  logic [IR_LEN-1:0] instr_ff;
  wire in_tlr    = (st_ff == ST_TLR);
  wire cap_ir    = (st_ff == ST_CAP_IR);
  wire sh_ir     = (st_ff == ST_SH_IR);
  wire upd_ir    = (st_ff == ST_UPD_IR);
  wire cap_dr    = (st_ff == ST_CAP_DR);
  wire sh_dr     = (st_ff == ST_SH_DR);
  wire upd_dr    = (st_ff == ST_UPD_DR);
  wire sel_bsr   = (instr_ff == INS_EXTEST) || (instr_ff == INS_SAMPLE);
  wire sel_id    = (instr_ff == INS_IDCODE);
  // High-z, bypass and every unused code take the one-stage path
  wire sel_byp   = !sel_bsr && !sel_id;

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  logic [IR_LEN-1:0] ir_sh_ff;

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      ir_sh_ff <= IR_CAPTURE;
    end else if (cap_ir) begin
      ir_sh_ff <= IR_CAPTURE;
    end else if (sh_ir) begin
      ir_sh_ff <= {i_tdi, ir_sh_ff[IR_LEN-1:1]};
    end
  end

  // Latched on the falling edge so the new instruction is stable by next rise
  logic ext_ff;
  logic hiz_ff;

  always_ff @(negedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      instr_ff <= INS_RESET;
      ext_ff   <= 1'b0;
      hiz_ff   <= 1'b0;
    end else if (in_tlr) begin
      instr_ff <= INS_RESET;
      ext_ff   <= 1'b0;
      hiz_ff   <= 1'b0;
    end else if (upd_ir) begin
      instr_ff <= ir_sh_ff;
      ext_ff   <= (ir_sh_ff == INS_EXTEST);
      hiz_ff   <= (ir_sh_ff == INS_HIGHZ);
    end
  end

  // ---------------------------------------------------------------
  // Pin sampling for boundary capture (three stages, agreement filter)
  // ---------------------------------------------------------------
  logic [BSR_LEN-1:0] ps1_ff;
  logic [BSR_LEN-1:0] ps2_ff;
  logic [BSR_LEN-1:0] ps3_ff;
  logic [BSR_LEN-1:0] pflt_ff;
  logic [BSR_LEN-1:0] nxt_pflt;

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      ps1_ff <= '0;
      ps2_ff <= '0;
      ps3_ff <= '0;
    end else begin
      ps1_ff <= i_pin_sample;
      ps2_ff <= ps1_ff;
      ps3_ff <= ps2_ff;
    end
  end

  // Per-bit agreement feeds one register, so each bit has a single writer
  genvar gp;
  generate
    for (gp = 0; gp < BSR_LEN; gp++) begin : g_pin_flt
      assign nxt_pflt[gp] = (ps2_ff[gp] == ps3_ff[gp]) ? ps3_ff[gp] : pflt_ff[gp];
    end
  endgenerate

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      pflt_ff <= '0;
    end else begin
      pflt_ff <= nxt_pflt;
    end
  end

  // ---------------------------------------------------------------
  // Test data registers, in parallel between TDI and TDO
  // ---------------------------------------------------------------
  logic               byp_ff;
  logic [ID_LEN-1:0]  id_sh_ff;
  logic [BSR_LEN-1:0] bsr_sh_ff;

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      byp_ff <= BYP_CAPTURE;
    end else if (cap_dr && sel_byp) begin
      byp_ff <= BYP_CAPTURE;
    end else if (sh_dr && sel_byp) begin
      byp_ff <= i_tdi;
    end
  end

  // Read only: shifting never alters the word that is captured next
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      id_sh_ff <= ID_WORD;
    end else if (cap_dr && sel_id) begin
      id_sh_ff <= ID_WORD;
    end else if (sh_dr && sel_id) begin
      id_sh_ff <= {i_tdi, id_sh_ff[ID_LEN-1:1]};
    end
  end

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      bsr_sh_ff <= '0;
    end else if (cap_dr && sel_bsr) begin
      bsr_sh_ff <= pflt_ff;
    end else if (sh_dr && sel_bsr) begin
      bsr_sh_ff <= {i_tdi, bsr_sh_ff[BSR_LEN-1:1]};
    end
  end

  // Update cells hold steady while the chain shifts underneath
  always_ff @(negedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      o_bsr_drive <= '0;
    end else if (upd_dr && sel_bsr) begin
      o_bsr_drive <= bsr_sh_ff;
    end
  end

  // ---------------------------------------------------------------
  // Serial output, falling edge
  // ---------------------------------------------------------------
  wire dr_bit  = sel_bsr ? bsr_sh_ff[0] : (sel_id ? id_sh_ff[0] : byp_ff);
  wire tdo_nxt = sh_ir ? ir_sh_ff[0] : dr_bit;

  always_ff @(negedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo    <= tdo_nxt;
      o_tdo_oe <= sh_ir || sh_dr;
    end
  end

  // Remembers that the port has been reset since power-up
  logic seen_rst_ff;

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      seen_rst_ff <= 1'b1;
    end else if (in_tlr) begin
      seen_rst_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Crossing of mode levels into the system clock
  // ---------------------------------------------------------------
  wire  [NUM_LEVELS-1:0] lvl_tck = {seen_rst_ff, ext_ff, hiz_ff};
  logic [NUM_LEVELS-1:0] ls1_ff;
  logic [NUM_LEVELS-1:0] ls2_ff;
  logic [NUM_LEVELS-1:0] ls3_ff;
  logic [NUM_LEVELS-1:0] lvl_ff;
  logic [NUM_LEVELS-1:0] nxt_lvl;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ls1_ff <= '0;
      ls2_ff <= '0;
      ls3_ff <= '0;
    end else begin
      ls1_ff <= lvl_tck;
      ls2_ff <= ls1_ff;
      ls3_ff <= ls2_ff;
    end
  end

  genvar gl;
  generate
    for (gl = 0; gl < NUM_LEVELS; gl++) begin : g_lvl_flt
      assign nxt_lvl[gl] = (ls2_ff[gl] == ls3_ff[gl]) ? ls3_ff[gl] : lvl_ff[gl];
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      lvl_ff <= '0;
    end else begin
      lvl_ff <= nxt_lvl;
    end
  end

  // Queues stay off until a port reset is seen and while extest owns the pins
  wire nxt_queue_en = lvl_ff[2] && !lvl_ff[1];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_queue_en    <= 1'b0;
      o_extest_mode <= 1'b0;
      o_out_hiz     <= 1'b0;
    end else begin
      o_queue_en    <= nxt_queue_en;
      o_extest_mode <= lvl_ff[1];
      o_out_hiz     <= lvl_ff[0];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  tms_reset_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    i_tms [*5] |=> st_ff == ST_TLR)
    else $error("five TMS-high clocks did not reach reset");

  sel_ir_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    (st_ff == ST_SEL_IR) && i_tms |=> st_ff == ST_TLR)
    else $error("select-IR with TMS high did not return to reset");

  ir_capture_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    cap_ir |=> ir_sh_ff[1:0] == 2'b01)
    else $error("instruction capture pattern wrong");

  ir_shift_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    sh_ir |=> ir_sh_ff[IR_LEN-1] == $past(i_tdi))
    else $error("instruction shift did not take TDI");

  ir_update_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    upd_ir |=> instr_ff == $past(ir_sh_ff))
    else $error("instruction not latched in update");

  byp_clear_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    cap_dr && sel_byp |=> byp_ff == 1'b0)
    else $error("bypass stage not cleared on capture");

  id_capture_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    cap_dr && sel_id |=> id_sh_ff == ID_WORD && id_sh_ff[0])
    else $error("identification word not captured");

  tlr_ident_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    in_tlr |=> instr_ff == INS_IDCODE && !ext_ff && !hiz_ff)
    else $error("reset state did not select identification");

  tdo_enable_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    (sh_ir || sh_dr) ##1 !(sh_ir || sh_dr) |-> $past(o_tdo_oe) && !o_tdo_oe)
    else $error("TDO enable does not follow shift states");

  queue_block_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_extest_mode |-> !o_queue_en)
    else $error("queues enabled during external test");

  byp_shift_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    sh_dr && sel_byp |=> byp_ff == $past(i_tdi))
    else $error("bypass stage did not take TDI");

  bsr_update_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    upd_dr && sel_bsr |=> o_bsr_drive == $past(bsr_sh_ff))
    else $error("boundary update cells not loaded");

  ir_pause_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    st_ff == ST_PAU_IR |=> $stable(ir_sh_ff))
    else $error("instruction stages moved during pause");

  dr_pause_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    st_ff == ST_PAU_DR |=> $stable(id_sh_ff) && $stable(bsr_sh_ff))
    else $error("data stages moved during pause");

  ir_tdo_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    sh_ir |-> o_tdo == ir_sh_ff[0])
    else $error("TDO does not show the instruction stage");

  byp_tdo_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    sh_dr && sel_byp |-> o_tdo == byp_ff)
    else $error("TDO does not show the bypass stage");

  hiz_path_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    hiz_ff |-> sel_byp)
    else $error("high-z instruction did not select bypass");

  rti_idle_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    st_ff == ST_RTI |=> $stable(byp_ff) && $stable(id_sh_ff) && $stable(o_bsr_drive))
    else $error("test logic active in idle");

endmodule : jtp_tap
`default_nettype wire

/* File: bench/jtp_ctrl_model.sv */
// Test controller model: drives the scan pins and collects serial data
`timescale 1ns/1ps
`default_nettype none
module jtp_ctrl_model (
  output logic      o_tck,     // Test clock, idle low between frames
  output logic      o_tms,     // Mode select
  output logic      o_tdi,     // Serial data to device
  output logic      o_trst_n,  // Test reset, active low
  input  wire logic i_tdo      // Resolved serial data from device
);
  event        res_ev;  // Raised once a scan has finished
  logic [31:0] res;     // Bits seen on the data line, first bit at 0

  initial begin
    o_tck    = 1'b0;
    o_tms    = 1'b1;
    o_tdi    = 1'b0;
    o_trst_n = 1'b1;
    res      = '0;
  end

  // Mode and data change at the falling edge, half a period before the device samples
  task automatic cyc(input logic m, input logic d, output logic q);
    o_tms = m;
    o_tdi = d;
    #40;
    o_tck = 1'b1;
    q     = i_tdo;
    #40;
    o_tck = 1'b0;
  endtask

  // Data line toggles outside shifts so a stale level never passes for data
  task automatic step(input logic m);
    logic q;
    cyc(m, ~o_tdi, q);
  endtask

  task automatic pulse_trst();
    o_trst_n = 1'b0;
    #60;
    o_trst_n = 1'b1;
    #60;
  endtask

  // n clocks with mode high, then one low clock to park in Run-Test-Idle
  task automatic tms_reset(input int n);
    #2.3;
    repeat (n) step(1'b1);
    step(1'b0);
  endtask

  // Scan from Run-Test-Idle; the scan pauses after bit pz
  task automatic scan(input logic ir, input int n, input int pz, input logic [31:0] din);
    logic q;
    #2.3;
    step(1'b1);
    if (ir) step(1'b1);
    step(1'b0);
    step(1'b0);
    res = '0;
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1 || i == pz, din[i], q);
      res[i] = q;
      if (i == pz && i != n - 1) begin
        step(1'b0);
        step(1'b0);
        step(1'b1);
        step(1'b0);
      end
    end
    step(1'b1);
    step(1'b0);
    -> res_ev;
    // Let the watcher take this result before the caller notes the next one
    #1;
  endtask
endmodule // jtp_ctrl_model
`default_nettype wire

/* File: bench/tb_jtp_tap.sv */
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin failures++; \
  $display("unexpected %s: expected %h seen %h", n, e, s); end end
module tb_jtp_tap
  import jtp_pkg::*;
;
  logic               i_ref_clk;
  logic               i_rstn;
  logic [BSR_LEN-1:0] i_pin_sample;
  logic [BSR_LEN-1:0] o_bsr_drive;
  logic               o_tdo, o_tdo_oe, o_extest_mode, o_out_hiz, o_queue_en;
  logic               tck, tms, tdi, trst_n;
  wire logic          tdo_pin;
  int                 failures = 0;
  int                 checks = 0;
  string              nm_q[$];
  logic [31:0]        exp_q[$];
  logic [31:0]        lvl_obs;
  logic [31:0]        d;
  logic [3:0]         codes [3];
  event               lvl_ev;

  // A released line shows the inverse, so a sample outside a shift is caught
  assign tdo_pin = o_tdo_oe ? o_tdo : ~o_tdo;

  initial i_ref_clk = 1'b0;
  always #2.5 i_ref_clk = ~i_ref_clk;

  jtp_ctrl_model ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n), .i_tdo(tdo_pin));

  jtp_tap dut (
    .i_ref_clk     (i_ref_clk),
    .i_rstn        (i_rstn),
    .i_tck         (tck),
    .i_trst_n      (trst_n),
    .i_tms         (tms),
    .i_tdi         (tdi),
    .o_tdo         (o_tdo),
    .o_tdo_oe      (o_tdo_oe),
    .i_pin_sample  (i_pin_sample),
    .o_bsr_drive   (o_bsr_drive),
    .o_extest_mode (o_extest_mode),
    .o_out_hiz     (o_out_hiz),
    .o_queue_en    (o_queue_en)
  );

  // ---------------------------------------------------------------
  // Scoreboard
  // ---------------------------------------------------------------
  task automatic note(input string n, input logic [31:0] e);
    nm_q.push_back(n);
    exp_q.push_back(e);
  endtask

  task automatic take(input logic [31:0] s);
    string       n;
    logic [31:0] e;
    n = (nm_q.size() > 0) ? nm_q.pop_front() : "result without note";
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~s;
    `CHK(n, e, s)
  endtask

  always @(ctl.res_ev) take(ctl.res);
  always @(lvl_ev) take(lvl_obs);

  task automatic end_sim();
    if (exp_q.size() != 0) failures++;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic show(input logic [31:0] v);
    lvl_obs = v;
    -> lvl_ev;
    @(posedge i_ref_clk);
    #1;
  endtask

  function automatic logic lv(input int k);
    case (k)
      0:       return o_queue_en;
      1:       return o_out_hiz;
      2:       return o_extest_mode;
      default: return o_tdo_oe;
    endcase
  endfunction

  // Ref-side levels pass a synchroniser, so allow a bounded settling time
  task automatic lvl(input string n, input int k, input logic e);
    int w;
    w = 0;
    while (lv(k) !== e && w < 40) begin
      @(posedge i_ref_clk);
      #1;
      w++;
    end
    note(n, {31'h0, e});
    show({31'h0, lv(k)});
    if (w >= 40) end_sim();
  endtask

  task automatic load_ir(input logic [3:0] c, input int pz);
    note("ir capture", {28'h0, IR_CAPTURE});
    ctl.scan(1'b1, IR_LEN, pz, {28'h0, c});
  endtask

  task automatic id_scan(input int pz);
    d = $urandom;
    note("ident word", ID_WORD);
    ctl.scan(1'b0, ID_LEN, pz, d);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    i_rstn       = 1'b0;
    d            = $urandom(26078);
    i_pin_sample = d[BSR_LEN-1:0];
    codes        = '{INS_BYPASS, INS_HIGHZ, 4'h9};
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rstn       = 1'b1;
    i_pin_sample = d[BSR_LEN-1:0];
    ctl.pulse_trst();
    ctl.tms_reset(0);
    lvl("queue enable", 0, 1'b1);
    lvl("outputs off", 1, 1'b0);
    id_scan(-1);
    // Mid-run system reset: levels drop at once and return through the synchroniser
    @(posedge i_ref_clk);
    #1;
    i_rstn = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    note("queue enable in reset", 32'h0);
    show({31'h0, o_queue_en});
    i_rstn = 1'b1;
    lvl("queue enable", 0, 1'b1);
    foreach (codes[k]) begin
      load_ir(codes[k], -1);
      d = $urandom;
      note("bypass path", {30'h0, d[0], BYP_CAPTURE});
      ctl.scan(1'b0, 2, -1, d);
      lvl("outputs off", 1, codes[k] === INS_HIGHZ);
      lvl("queue enable", 0, 1'b1);
    end
    load_ir(INS_IDCODE, 1);
    id_scan(9);
    id_scan(-1);
    lvl("data out enable", 3, 1'b0);
    d = $urandom;
    i_pin_sample = d[BSR_LEN-1:0];
    load_ir(INS_SAMPLE, -1);
    d = $urandom;
    note("boundary capture", {24'h0, i_pin_sample});
    ctl.scan(1'b0, BSR_LEN, 3, d);
    note("boundary drive", {24'h0, d[7:0]});
    show({24'h0, o_bsr_drive});
    lvl("extest mode", 2, 1'b0);
    load_ir(INS_EXTEST, -1);
    lvl("extest mode", 2, 1'b1);
    lvl("queue enable", 0, 1'b0);
    // Reset from inside a data shift, the least convenient place
    ctl.step(1'b1);
    ctl.step(1'b0);
    ctl.step(1'b0);
    ctl.tms_reset(TMS_RESET_N);
    lvl("extest mode", 2, 1'b0);
    lvl("queue enable", 0, 1'b1);
    id_scan(-1);
    load_ir(INS_BYPASS, -1);
    repeat (3) ctl.step(1'b1);
    ctl.step(1'b0);
    id_scan(-1);
    end_sim();
  end

  initial begin
    #300000;
    failures++;
    end_sim();
  end
endmodule // tb_jtp_tap
`default_nettype wire
